// ---- rtl/nfs_seq.sv ----
// How it works
// - programs within a block go to pages in ascending order from the first page written there.
// - a lower-group page is programmed before its paired upper-group page, which ascending order assures.
// - the host raises chip select between data cycles when the user stalls, without aborting.
// - a cache read run is kept inside one block.
// - a cache read run ends with 3Fh when its last request is a cache read; a program request can close it with 10h.
// - copy-back is not issued by this sequencer, so plane limits hold trivially.
// - a cache program run is kept inside one block.
// - between 11h and 81h only status or reset may be issued; two-plane program is not issued here.
// - a cache program run ends with 80h then 10h when its last request is a program; a last cache read closes it with 3Fh.
`timescale 1ns/1ps
module nfs_seq
    import nfs_pkg::*;
#(
    parameter int RST_WAIT  = RST_CYC,
    parameter int PROG_WAIT = PROG_CYC
)
(
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_b_in,
    // request
    input  wire logic        req_valid_in,
    input  wire nfs_req_type req_in,
    output logic             req_ready_out,
    output logic             req_reject_out,
    output logic             done_out,
    // write data stream
    input  wire logic        wr_valid_in,
    input  wire logic [7:0]  wr_data_in,
    output logic             wr_ready_out,
    // read data stream
    output logic             rd_valid_out,
    output logic [7:0]       rd_data_out,
    // flash pins
    output nfs_pins_type     pins_out,
    output logic [7:0]       io_out,
    output logic             io_oe_out,
    input  wire logic [7:0]  io_in,
    input  wire logic        ready_busy_in
);
    typedef enum {
        ST_IDLE, ST_CMD1, ST_ADDR, ST_DATA, ST_CMD2, ST_WAIT, ST_RDOUT, ST_END_CMD
    } nfs_state_type;

    nfs_state_type      state;
    nfs_req_type        cur;
    logic [2:0]         addr_cnt;
    logic [13:0]        col;
    logic [3:0]         ph;
    logic [23:0]        wait_cnt;
    logic               run_open;
    logic [BLOCK_W-1:0] run_block;
    logic               allowed;
    logic               commit;
    logic               accept;
    logic               is_prog;
    logic               same_run;
    logic [7:0]         addr_byte;

    nfs_page_track u_track (
        .clk_sys_in  (clk_sys_in),
        .rst_b_in    (rst_b_in),
        .block_in    (req_in.block),
        .page_in     (req_in.page),
        .allowed_out (allowed),
        .commit_in   (commit),
        .erase_in    (1'b0)
    );

    ////////////////////////////////////////////////////////////////
    assign is_prog  = (req_in.op == NFS_OP_PROGRAM) || (req_in.op == NFS_OP_CACHE_PROG);
    // an open run may only continue in its own block
    assign same_run = !run_open || (req_in.block == run_block);
    // taken only at an edge where ready stood, so valid and ready pair cleanly
    assign accept   = req_ready_out && req_valid_in
                    && (!is_prog || allowed) && (req_in.op == NFS_OP_RESET || same_run);
    assign commit   = accept && is_prog;

    always_comb
    begin
        unique case (addr_cnt)
            3'h0:    addr_byte = 8'h00;
            3'h1:    addr_byte = 8'h00;
            3'h2:    addr_byte = {cur.block[0], cur.page};
            3'h3:    addr_byte = cur.block[8:1];
            default: addr_byte = {5'h00, cur.block[11:9]};
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // main sequencer; each pin cycle is we low for ph then high
    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state          <= ST_IDLE;
            cur            <= '0;
            addr_cnt       <= 3'h0;
            col            <= 14'h0000;
            ph             <= 4'h0;
            wait_cnt       <= 24'h000000;
            run_open       <= 1'b0;
            run_block      <= '0;
            req_ready_out  <= 1'b0;
            req_reject_out <= 1'b0;
            done_out       <= 1'b0;
            wr_ready_out   <= 1'b0;
            rd_valid_out   <= 1'b0;
            rd_data_out    <= 8'h00;
            pins_out       <= '{cle: 1'b0, ale: 1'b0, ce_b: 1'b1, we_b: 1'b1, read_strobe_low: 1'b1};
            io_out         <= 8'h00;
            io_oe_out      <= 1'b0;
        end
        else
        begin
            req_ready_out  <= (state == ST_IDLE) && !accept;
            req_reject_out <= req_ready_out && req_valid_in && !accept;
            done_out       <= 1'b0;
            rd_valid_out   <= 1'b0;
            wr_ready_out   <= 1'b0;
            unique case (state)
                ST_IDLE:
                begin
                    pins_out.ce_b <= 1'b1;
                    io_oe_out     <= 1'b0;
                    if (accept)
                    begin
                        cur      <= req_in;
                        addr_cnt <= 3'h0;
                        col      <= 14'h0000;
                        ph       <= 4'h0;
                        state    <= ST_CMD1;
                        if (req_in.op != NFS_OP_RESET)
                        begin
                            run_open  <= (req_in.op != NFS_OP_PROGRAM) && !req_in.last;
                            run_block <= req_in.block;
                        end
                        else
                            run_open  <= 1'b0;
                    end
                end
                ST_CMD1, ST_CMD2, ST_END_CMD, ST_ADDR, ST_DATA:
                begin
                    pins_out.ce_b <= 1'b0;
                    pins_out.cle  <= (state != ST_ADDR) && (state != ST_DATA);
                    pins_out.ale  <= (state == ST_ADDR);
                    io_oe_out     <= 1'b1;
                    if (state == ST_DATA && ph == 4'h0 && !wr_valid_in)
                        pins_out.ce_b <= 1'b1;
                    else
                    begin
                        ph <= ph + 4'h1;
                        if (ph == 4'h0)
                        begin
                            pins_out.we_b <= 1'b0;
                            unique case (state)
                                ST_CMD1:    io_out <= cur.op == NFS_OP_RESET ? CMD_RESET
                                                    : cur.op == NFS_OP_CACHE_READ ? CMD_READ_1ST : CMD_PROG_1ST;
                                ST_CMD2:    io_out <= cur.op == NFS_OP_CACHE_READ
                                                    ? (cur.last ? CMD_CACHE_RD_END : CMD_CACHE_RD)
                                                    : cur.op == NFS_OP_CACHE_PROG && !cur.last
                                                    ? CMD_CACHE_PROG : CMD_PROG_2ND;
                                ST_END_CMD: io_out <= CMD_READ_2ND;
                                ST_ADDR:    io_out <= addr_byte;
                                default:    io_out <= wr_data_in;
                            endcase
                            wr_ready_out <= (state == ST_DATA);
                        end
                        else if (ph == WP_CYC)
                            pins_out.we_b <= 1'b1;
                        else if (ph == WP_CYC + WH_CYC)
                        begin
                            ph <= 4'h0;
                            unique case (state)
                                ST_CMD1:
                                    state <= cur.op == NFS_OP_RESET ? ST_WAIT : ST_ADDR;
                                ST_ADDR:
                                begin
                                    addr_cnt <= addr_cnt + 3'h1;
                                    if (addr_cnt == 3'(NUM_ADDR_CYC - 1))
                                        state <= cur.op == NFS_OP_CACHE_READ ? ST_END_CMD : ST_DATA;
                                end
                                ST_END_CMD:
                                    state <= ST_CMD2;
                                ST_DATA:
                                begin
                                    col <= col + 14'h0001;
                                    if (col == LAST_COL)
                                        state <= ST_CMD2;
                                end
                                default:
                                begin
                                    state    <= ST_WAIT;
                                    wait_cnt <= 24'h000000;
                                end
                            endcase
                        end
                    end
                end
                ST_WAIT:
                begin
                    // reset gets a hard timeout over ready at RST_WAIT, every other request at PROG_WAIT
                    pins_out.cle  <= 1'b0;
                    pins_out.ale  <= 1'b0;
                    io_oe_out     <= 1'b0;
                    wait_cnt      <= wait_cnt + 24'h000001;
                    if (wait_cnt > 24'(WHR_CYC) && (ready_busy_in
                        || (cur.op == NFS_OP_RESET && wait_cnt >= 24'(RST_WAIT))
                        || wait_cnt >= 24'(PROG_WAIT)))
                    begin
                        col <= 14'h0000;
                        ph  <= 4'h0;
                        if (cur.op == NFS_OP_CACHE_READ)
                            state <= ST_RDOUT;
                        else
                        begin
                            done_out <= 1'b1;
                            state    <= ST_IDLE;
                        end
                    end
                end
                default:
                begin
                    // ST_RDOUT: one byte per strobe, column counted from zero
                    pins_out.ce_b <= 1'b0;
                    ph            <= ph + 4'h1;
                    if (ph == 4'h0)
                        pins_out.read_strobe_low <= 1'b0;
                    else if (ph == WP_CYC + 4'h1)
                    begin
                        pins_out.read_strobe_low <= 1'b1;
                        rd_data_out  <= io_in;
                        rd_valid_out <= 1'b1;
                    end
                    else if (ph == WP_CYC + WH_CYC + 4'h1)
                    begin
                        ph  <= 4'h0;
                        col <= col + 14'h0001;
                        if (col == LAST_COL)
                        begin
                            done_out <= 1'b1;
                            state    <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end
endmodule : nfs_seq

// ---- rtl/nfs_pkg.sv ----
package nfs_pkg;

    // command codes
    localparam logic [7:0] CMD_READ_1ST     = 8'h00;
    localparam logic [7:0] CMD_READ_2ND     = 8'h30;
    localparam logic [7:0] CMD_CACHE_RD     = 8'h31;
    localparam logic [7:0] CMD_CACHE_RD_END = 8'h3F;
    localparam logic [7:0] CMD_PROG_1ST     = 8'h80;
    localparam logic [7:0] CMD_PROG_2ND     = 8'h10;
    localparam logic [7:0] CMD_CACHE_PROG   = 8'h15;
    localparam logic [7:0] CMD_STATUS       = 8'h70;
    localparam logic [7:0] CMD_RESET        = 8'hFF;

    // geometry
    localparam int         PAGE_W           = 7;
    localparam int         BLOCK_W          = 12;
    localparam int         NUM_BLOCKS       = 4096;
    localparam int         NUM_ADDR_CYC     = 5;
    localparam int         STATUS_RDY_BIT   = 6;
    localparam int         PAGE_BYTES       = 8704;
    localparam logic [13:0] LAST_COL        = 14'h21FF;

    // timing: pin phases in clock cycles
    localparam int         CLK_NS           = 10;
    localparam int         T_WP_NS          = 11;
    localparam int         T_WH_NS          = 11;
    localparam int         T_WHR_NS         = 120;
    localparam int         T_RST_US         = 10;
    localparam int         T_PROG_MS        = 10;
    localparam logic [3:0] WP_CYC           = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] WH_CYC           = 4'((T_WH_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] WHR_CYC          = 4'h0 + 4'((T_WHR_NS / 10 + 1) > 15 ? 15 : (T_WHR_NS / 10 + 1));
    localparam int         RST_CYC          = (T_RST_US * 1000) / CLK_NS;
    localparam int         PROG_CYC         = (T_PROG_MS * 1000000) / CLK_NS;

    // request kinds
    typedef enum logic [1:0] {
        NFS_OP_PROGRAM,
        NFS_OP_CACHE_PROG,
        NFS_OP_CACHE_READ,
        NFS_OP_RESET
    } nfs_op_type;

    typedef struct packed {
        nfs_op_type             op;
        logic [BLOCK_W-1:0]     block;
        logic [PAGE_W-1:0]      page;
        logic                   last;
    } nfs_req_type;

    typedef struct packed {
        logic                   cle;
        logic                   ale;
        logic                   ce_b;
        logic                   we_b;
        logic                   read_strobe_low;
    } nfs_pins_type;

endpackage : nfs_pkg

// ---- rtl/nfs_page_track.sv ----
`timescale 1ns/1ps
module nfs_page_track
    import nfs_pkg::*;
(
    // clock and reset
    input  wire logic               clk_sys_in,
    input  wire logic               rst_b_in,
    // query
    input  wire logic [BLOCK_W-1:0] block_in,
    input  wire logic [PAGE_W-1:0]  page_in,
    output logic                    allowed_out,
    // update
    input  wire logic               commit_in,
    input  wire logic               erase_in
);
    // next permitted page plus a used flag per block
    logic [PAGE_W:0] next_page [NUM_BLOCKS];
    logic [NUM_BLOCKS-1:0] used;

    ////////////////////////////////////////////////////////////////
    // ascending only; first page of a fresh block may be anywhere
    assign allowed_out = !used[block_in] || ({1'b0, page_in} >= next_page[block_in]);

    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            used <= '0;
        // set wins over clear in one cycle
        else if (commit_in)
            used[block_in] <= 1'b1;
        else if (erase_in)
            used[block_in] <= 1'b0;
    end

    // array has no reset; the used flag guards stale entries
    always_ff @(posedge clk_sys_in)
    begin
        if (commit_in)
            next_page[block_in] <= {1'b0, page_in} + 8'h01;
    end
endmodule : nfs_page_track

// ---- sim/nfs_seq_properties.sv ----
`timescale 1ns/1ps
module nfs_seq_properties
    import nfs_pkg::*;
#(
    parameter int RST_WAIT  = RST_CYC,
    parameter int PROG_WAIT = PROG_CYC
)
(
    // clock and reset
    input wire logic         clk_sys_in,
    input wire logic         rst_b_in,
    // request side
    input wire logic         req_ready_out,
    input wire logic         req_reject_out,
    input wire logic         done_out,
    input wire logic         wr_ready_out,
    // flash pins
    input wire nfs_pins_type pins_out,
    input wire logic [7:0]   io_out,
    input wire logic         io_oe_out,
    // flash status
    input wire logic         ready_busy_in
);
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_b_in);
    ////////////////////////////////////////
    sequence s_we_low;
        !pins_out.we_b ##1 !pins_out.we_b;
    endsequence
    sequence s_we_high;
        pins_out.we_b ##1 pins_out.we_b;
    endsequence
    property p_we_ce; !pins_out.we_b |-> !pins_out.ce_b; endproperty
    a_we_ce: assert property (p_we_ce) else $error("write strobe without chip select");
    property p_rd_pins; !pins_out.read_strobe_low |-> !pins_out.ce_b && pins_out.we_b && !io_oe_out; endproperty
    a_rd_pins: assert property (p_rd_pins) else $error("read strobe with bad pin state");
    property p_latch; !(pins_out.cle && pins_out.ale); endproperty
    a_latch: assert property (p_latch) else $error("command and address latch together");
    // two clocks low then at least two high per bus cycle
    property p_we_shape; $fell(pins_out.we_b) |-> s_we_low ##1 s_we_high; endproperty
    a_we_shape: assert property (p_we_shape) else $error("write strobe shape wrong");
    property p_io_hold; $fell(pins_out.we_b) |=> ($stable(io_out) && $stable(pins_out.ale)) [*2]; endproperty
    a_io_hold: assert property (p_io_hold) else $error("bus moved under write strobe");
    property p_rej_quiet; req_reject_out |-> pins_out.ce_b && $past(pins_out.ce_b); endproperty
    a_rej_quiet: assert property (p_rej_quiet) else $error("refused request touched pins");
    property p_rej_pulse; req_reject_out |=> !req_reject_out && !done_out; endproperty
    a_rej_pulse: assert property (p_rej_pulse) else $error("refusal not a single pulse");
    property p_done_pulse; done_out |=> !done_out; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done not a single pulse");
    property p_wr_take; wr_ready_out |-> io_oe_out && !pins_out.cle && !pins_out.ale; endproperty
    a_wr_take: assert property (p_wr_take) else $error("byte taken outside data cycle");
    property p_idle; req_ready_out |-> pins_out.ce_b && !io_oe_out; endproperty
    a_idle: assert property (p_idle) else $error("idle with chip selected");
    // a reset into a running program may spoil the page and its pair
    property p_no_cut; $fell(pins_out.we_b) && pins_out.cle && io_out == CMD_RESET |-> ready_busy_in; endproperty
    a_no_cut: assert property (p_no_cut) else $error("reset sent while flash busy");
endmodule : nfs_seq_properties
bind nfs_seq nfs_seq_properties #(.RST_WAIT(RST_WAIT), .PROG_WAIT(PROG_WAIT)) u_props (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .req_ready_out(req_ready_out),
    .req_reject_out(req_reject_out), .done_out(done_out), .wr_ready_out(wr_ready_out),
    .pins_out(pins_out), .io_out(io_out), .io_oe_out(io_oe_out), .ready_busy_in(ready_busy_in));

// ---- sim/nfs_flash_model.sv ----
`timescale 1ns/1ps
module nfs_flash_model
    import nfs_pkg::*;
#(
    parameter int RST_BUSY  = 60,
    parameter int PROG_BUSY = 150,
    parameter int RD_BUSY   = 40
)
(
    // clock and reset
    input  wire logic         clk_sys_in,
    input  wire logic         rst_b_in,
    // host pins
    input  wire nfs_pins_type pins_in,
    input  wire logic [7:0]   io_in,
    output logic [7:0]        io_out,
    output logic              ready_busy_out,
    // observation
    output logic [7:0]        last_cmd_out,
    output logic [15:0]       nbytes_out,
    output logic [7:0]        sum_out
);
    logic [15:0] busy;
    logic [13:0] col;
    logic        prev_we;
    logic        prev_rd;
    logic        stat;
    logic [7:0]  dq;
    assign ready_busy_out = (busy == 16'h0000);
    // released bus shows the inverse, so a stale sample cannot pass
    assign io_out = (!pins_in.ce_b && !prev_rd) ? dq : ~dq;
    ////////////////////////////////////////
    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            busy <= 16'h0000;
            col <= 14'h0000;
            prev_we <= 1'b1;
            prev_rd <= 1'b1;
            stat <= 1'b0;
            dq <= 8'h00;
            last_cmd_out <= 8'h00;
            nbytes_out <= 16'h0000;
            sum_out <= 8'h00;
        end
        else
        begin
            prev_we <= pins_in.we_b;
            prev_rd <= pins_in.read_strobe_low;
            if (busy != 16'h0000)
                busy <= busy - 16'h0001;
            // loaded state is untouched while chip select is high
            if (pins_in.we_b && !prev_we && !pins_in.ce_b && pins_in.cle)
            begin
                last_cmd_out <= io_in;
                stat <= (io_in == CMD_STATUS);
                if (io_in == CMD_PROG_1ST)
                begin
                    nbytes_out <= 16'h0000;
                    sum_out <= 8'h00;
                end
                if (io_in == CMD_RESET)
                    busy <= 16'(RST_BUSY);
                if (io_in == CMD_PROG_2ND || io_in == CMD_CACHE_PROG)
                    busy <= 16'(PROG_BUSY);
                if (io_in == CMD_READ_2ND || io_in == CMD_CACHE_RD || io_in == CMD_CACHE_RD_END)
                begin
                    busy <= 16'(RD_BUSY);
                    col <= 14'h0000;
                end
            end
            else if (pins_in.we_b && !prev_we && !pins_in.ce_b && !pins_in.ale)
            begin
                nbytes_out <= nbytes_out + 16'h0001;
                sum_out <= sum_out ^ io_in;
            end
            if (!pins_in.read_strobe_low && prev_rd && !pins_in.ce_b)
            begin
                dq <= stat ? {1'b0, ready_busy_out, 6'h00} : (col[7:0] ^ {2'h0, col[13:8]});
                col <= col + 14'h0001;
            end
        end
    end
endmodule : nfs_flash_model

// ---- sim/tb.sv ----
`timescale 1ns/1ps
module tb;
    import nfs_pkg::*;
    logic         clk_sys_in = 1'b0;
    logic         rst_b_in = 1'b0;
    logic         req_valid_in = 1'b0;
    nfs_req_type  req_in = '0;
    logic         wr_valid_in = 1'b0;
    logic [7:0]   wr_data_in = 8'h00;
    logic         req_ready_out, req_reject_out, done_out, wr_ready_out, rd_valid_out, io_oe_out, ready_busy_in;
    logic [7:0]   rd_data_out, io_out, flash_io, io_bus, last_cmd, sum, tb_sum;
    nfs_pins_type pins_out;
    logic [15:0]  nbytes;
    logic [11:0]  blk_a;
    logic [9:0]   expq[$];
    int           fails = 0;
    int           checks = 0;
    always #5 clk_sys_in = ~clk_sys_in;
    assign io_bus = io_oe_out ? io_out : flash_io;
    nfs_seq #(.RST_WAIT(200), .PROG_WAIT(400)) u_dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
        .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
        .req_reject_out(req_reject_out), .done_out(done_out), .wr_valid_in(wr_valid_in),
        .wr_data_in(wr_data_in), .wr_ready_out(wr_ready_out), .rd_valid_out(rd_valid_out),
        .rd_data_out(rd_data_out), .pins_out(pins_out), .io_out(io_out), .io_oe_out(io_oe_out),
        .io_in(io_bus), .ready_busy_in(ready_busy_in));
    nfs_flash_model u_flash (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .pins_in(pins_out),
        .io_in(io_bus), .io_out(flash_io), .ready_busy_out(ready_busy_in), .last_cmd_out(last_cmd),
        .nbytes_out(nbytes), .sum_out(sum));
    ////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop
    // request held until an edge that sees the sequencer idle
    task automatic do_req(input nfs_op_type kind, input logic [11:0] blk, input logic [6:0] pg,
                          input logic lst, input logic [9:0] exp);
        logic taken;
        expq.push_back(exp);
        req_in = {kind, blk, pg, lst};
        req_valid_in = 1'b1;
        taken = 1'b0;
        // ready looked at 1 ns after an edge, then the edge that samples it passes
        while (!taken)
        begin
            taken = (req_ready_out === 1'b1);
            @(posedge clk_sys_in);
        end
        #1;
        req_valid_in = 1'b0;
        repeat (200000)
        begin
            if (done_out === 1'b1 || req_reject_out === 1'b1)
                break;
            @(posedge clk_sys_in);
            #1;
        end
        @(posedge clk_sys_in);
        #1;
    endtask : do_req
    ////////////////////////////////////////
    // writer stalls at random so chip select drops between data cycles
    always @(posedge clk_sys_in)
    begin
        #1;
        if (wr_ready_out === 1'b1 && wr_valid_in)
        begin
            tb_sum = tb_sum ^ wr_data_in;
            wr_data_in = 8'($urandom);
            wr_valid_in = ($urandom % 4) != 0;
        end
        else if (!wr_valid_in && rst_b_in)
            wr_valid_in = ($urandom % 3) == 0;
    end
    // sampled mid-cycle, away from the updating edge
    always @(negedge clk_sys_in)
    begin
        if (rst_b_in && (done_out || req_reject_out || rd_valid_out))
            check(16'({done_out, req_reject_out, rd_valid_out ? rd_data_out : 8'h00}),
                  16'(expq.size() > 0 ? expq.pop_front() : 10'h3FF));
    end
    initial
    begin
        repeat (150000) @(posedge clk_sys_in);
        fails++;
        report_and_stop();
    end
    initial
    begin
        void'($urandom(32'h7A54));
        blk_a = 12'($urandom);
        tb_sum = 8'h00;
        repeat (3) @(posedge clk_sys_in);
        #1;
        rst_b_in = 1'b1;
        @(posedge clk_sys_in);
        #1;
        do_req(NFS_OP_RESET, blk_a, 7'h00, 1'b1, 10'h200);
        check(16'(last_cmd), 16'(CMD_RESET));
        tb_sum = 8'h00;
        do_req(NFS_OP_PROGRAM, blk_a, 7'h03, 1'b1, 10'h200);
        check(nbytes, 16'(PAGE_BYTES));
        check(16'(sum), 16'(tb_sum));
        do_req(NFS_OP_PROGRAM, blk_a, 7'h02, 1'b1, 10'h100);
        check(16'(last_cmd), 16'(CMD_PROG_2ND));
        for (int c = 0; c < PAGE_BYTES; c++)
            expq.push_back({2'b00, 8'(c) ^ 8'(c >> 8)});
        do_req(NFS_OP_CACHE_READ, blk_a ^ 12'h001, 7'h00, 1'b0, 10'h200);
        check(16'(last_cmd), 16'(CMD_CACHE_RD));
        do_req(NFS_OP_CACHE_PROG, blk_a, 7'h04, 1'b1, 10'h100);
        do_req(NFS_OP_RESET, blk_a, 7'h00, 1'b1, 10'h200);
        check(16'(last_cmd), 16'(CMD_RESET));
        check(16'(expq.size()), 16'h0000);
        report_and_stop();
    end
endmodule : tb
